// [verilog/bssl_defines.svh]
`ifndef BSSL_DEFINES_SVH
`define BSSL_DEFINES_SVH

// apb register byte offsets
`define BSSL_OFF_CTRL 12'h000
`define BSSL_OFF_BOOT 12'h004
`define BSSL_OFF_LSTAT 12'h008
`define BSSL_OFF_REC 12'h00C
`define BSSL_OFF_DATA 12'h010
`define BSSL_OFF_NVM 12'h014
`define BSSL_ADDR_W 12

// ctrl register fields
`define BSSL_CTRL_FLASH_IDLE_REQUEST 6
`define BSSL_CTRL_BOOTEN 7
`define BSSL_CTRL_IDLE 0
`define BSSL_CTRL_PGMFAIL 1
`define BSSL_CTRL_PGMERR 2
`define BSSL_CTRL_ERASE 3

// boot vector constants
`define BSSL_RESET_PC 16'h0000
`define BSSL_DEF_PSW 16'h8000
`define BSSL_DEF_PC 16'hF800
`define BSSL_LOADER_PC 16'hF900
`define BSSL_ROM_BASE 16'hF800
`define BSSL_ERASED_STATUS 8'h00
`define BSSL_ERROR_STATUS 8'hFF

// timing
`define BSSL_CLK_MHZ 250
`define BSSL_FM_WAKE_US 3
`define BSSL_FM_WAKE_CYC (`BSSL_FM_WAKE_US * `BSSL_CLK_MHZ)

// serial characters, record data limit and record types
`define BSSL_CH_F 8'h66
`define BSSL_CH_COLON 8'h3A
`define BSSL_CH_CR 8'h0D
`define BSSL_CH_LF 8'h0A
`define BSSL_CH_DOT 8'h2E
`define BSSL_CH_X 8'h58
`define BSSL_CH_R 8'h52
`define BSSL_MAX_DATA 5'd16
`define BSSL_REC_DATA 8'h00
`define BSSL_REC_EOF 8'h01

`endif

// [verilog/bssl_pkg.sv]
package bssl_pkg;
  typedef enum logic [2:0] {
    BSSL_BAUD = 3'b000,
    BSSL_WAIT = 3'b001,
    BSSL_HDR = 3'b010,
    BSSL_BODY = 3'b011,
    BSSL_TAIL = 3'b100,
    BSSL_EXEC = 3'b101,
    BSSL_REPLY = 3'b110
  } bssl_state_e;
  typedef logic [15:0] bssl_word_t;
endpackage

// [verilog/bssl_uart.sv]
`timescale 1ns/1ps
`include "bssl_defines.svh"
// serial engine; bit time learned from the start bit of the first 'f'
module bssl_uart (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // receive side
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic baud_locked,
  // transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic tx_busy
);
  logic [19:0] bit_cyc;
  logic [19:0] rcnt;
  logic [3:0] rbit;
  logic [7:0] rsh;
  logic rbusy;
  logic measuring;
  logic [19:0] tcnt;
  logic [3:0] tbit;
  logic [9:0] tsh;

  // receiver; bit time measured as the low span of the 'f' start bit, whose
  // next bit (lsb of 8'h66) is 0 too, so the first low run is two bits long
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cyc <= 20'h00000;
      baud_locked <= 1'b0;
      measuring <= 1'b0;
      rcnt <= 20'h00000;
      rbit <= 4'h0;
      rsh <= 8'h00;
      rbusy <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (!baud_locked) begin
        if (!measuring && !rxd) begin
          measuring <= 1'b1;
          rcnt <= 20'h00001;
        end else if (measuring && !rxd) begin
          rcnt <= rcnt + 20'h00001;
        end else if (measuring) begin
          bit_cyc <= {1'b0, rcnt[19:1]};
          baud_locked <= 1'b1;
          measuring <= 1'b0;
          rbusy <= 1'b1;
          rbit <= 4'h2;
          rcnt <= {2'b00, rcnt[19:2]};
          rsh <= 8'h00;
        end
      end else if (!rbusy) begin
        if (!rxd) begin
          rbusy <= 1'b1;
          rbit <= 4'h0;
          rcnt <= {1'b0, bit_cyc[19:1]};
        end
      end else if (rcnt != 20'h00000) begin
        rcnt <= rcnt - 20'h00001;
      end else begin
        rcnt <= bit_cyc;
        rbit <= rbit + 4'h1;
        if (rbit >= 4'h1 && rbit <= 4'h8) begin
          rsh <= {rxd, rsh[7:1]};
        end
        if (rbit == 4'h9) begin
          rbusy <= 1'b0;
          rx_data <= rsh;
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // transmitter, 8n1 at learned rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      tx_busy <= 1'b0;
      tcnt <= 20'h00000;
      tbit <= 4'h0;
      tsh <= 10'h3FF;
    end else if (clk_en) begin
      if (!tx_busy) begin
        if (tx_start) begin
          tx_busy <= 1'b1;
          tsh <= {1'b1, tx_data, 1'b0};
          tbit <= 4'h0;
          tcnt <= 20'h00000;
        end
      end else if (tcnt != 20'h00000) begin
        tcnt <= tcnt - 20'h00001;
      end else if (tbit == 4'hA) begin
        tx_busy <= 1'b0;
      end else begin
        txd <= tsh[0];
        tsh <= {1'b1, tsh[9:1]};
        tbit <= tbit + 4'h1;
        tcnt <= bit_cyc;
      end
    end
  end
endmodule // bssl_uart

// [verilog/bssl_loader.sv]
`timescale 1ns/1ps
`include "bssl_defines.svh"
module bssl_loader
  import bssl_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset straps
  input wire logic program_store_strobe_n,
  input wire logic addr_latch,
  input wire logic external_access_n,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // system side
  output logic [15:0] boot_program_counter,
  output logic [15:0] boot_status_word,
  output logic boot_rom_enable,
  output logic watchdog_disable,
  output logic flash_power_down,
  output logic cpu_hold
);
  import bssl_pkg::*;

  // non-volatile special cells, reset keeps their content
  logic [7:0] status_byte;
  bssl_word_t vec_pc;
  bssl_word_t vec_psw;
  logic nvm_init;
  logic started;
  logic flash_idle_request;
  logic cpu_idle;
  logic pgm_fail;
  logic [11:0] wake_cnt;
  bssl_state_e state;
  logic [7:0] buffer [0:15];
  logic [7:0] rec_count;
  logic [15:0] rec_addr;
  logic [7:0] rec_type;
  logic [7:0] sum;
  logic [5:0] nib_idx;
  logic [3:0] hi_nib;
  logic [7:0] reply;
  logic [7:0] last_reply;
  logic [7:0] rx_data;
  logic rx_valid;
  logic baud_locked;
  logic tx_busy;
  logic [7:0] tx_data;
  logic tx_start;
  logic [3:0] nib;
  logic nib_ok;
  logic wr_en;
  logic rd_en;
  logic [7:0] byte_val;

  // ascii hex to nibble, used for every record character
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) hex_val = {1'b1, 4'(c - 8'h30)};
    else if (c >= 8'h41 && c <= 8'h46) hex_val = {1'b1, 4'(c - 8'h37)};
    else if (c >= 8'h61 && c <= 8'h66) hex_val = {1'b1, 4'(c - 8'h57)};
    else hex_val = 5'h00;
  endfunction

  assign {nib_ok, nib} = hex_val(rx_data);
  assign byte_val = {hi_nib, nib};
  assign wr_en = psel && penable && pwrite && clk_en;
  assign rd_en = psel && !penable && !pwrite;

  bssl_uart u_uart (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .rxd(rxd),
    .txd(txd),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .baud_locked(baud_locked),
    .tx_data(tx_data),
    .tx_start(tx_start),
    .tx_busy(tx_busy)
  );

  // boot decision on the first enabled edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started <= 1'b0;
      boot_rom_enable <= 1'b0;
      boot_program_counter <= `BSSL_RESET_PC;
      boot_status_word <= 16'h0000;
      watchdog_disable <= 1'b0;
      cpu_hold <= 1'b1;
    end else if (clk_en) begin
      if (!started) begin
        started <= 1'b1;
        cpu_hold <= 1'b0;
        if (status_byte != `BSSL_ERASED_STATUS || (!program_store_strobe_n && addr_latch &&
            external_access_n)) begin
          boot_rom_enable <= 1'b1;
          boot_program_counter <= vec_pc;
          boot_status_word <= vec_psw;
          watchdog_disable <= (vec_pc == `BSSL_DEF_PC);
        end else begin
          boot_program_counter <= `BSSL_RESET_PC;
        end
      end else if (wr_en && paddr == `BSSL_OFF_CTRL) begin
        boot_rom_enable <= pwdata[`BSSL_CTRL_BOOTEN];
      end
    end
  end

  // special cells: factory defaults once, error forcing, paired erase
  always_ff @(posedge pclk) begin
    if (nvm_init !== 1'b1) begin
      status_byte <= `BSSL_ERROR_STATUS;
      vec_pc <= `BSSL_DEF_PC;
      vec_psw <= `BSSL_DEF_PSW;
    end else if (clk_en) begin
      if (wr_en && paddr == `BSSL_OFF_CTRL && pwdata[`BSSL_CTRL_PGMERR]) begin
        status_byte <= `BSSL_ERROR_STATUS;
      end else if (wr_en && paddr == `BSSL_OFF_CTRL && pwdata[`BSSL_CTRL_ERASE]) begin
        status_byte <= `BSSL_ERASED_STATUS;
        vec_pc <= 16'h0000;
        vec_psw <= 16'h0000;
      end else if (wr_en && paddr == `BSSL_OFF_NVM) begin
        status_byte <= pwdata[7:0];
      end else if (wr_en && paddr == `BSSL_OFF_BOOT) begin
        vec_pc <= pwdata[15:0];
        vec_psw <= pwdata[31:16];
      end
    end
  end

  // power-on marker for the special cells, survives ordinary resets
  always_ff @(posedge pclk) begin
    nvm_init <= 1'b1; // unknown only before the very first edge
  end

  // flash idle: request bit plus cpu idle gates flash, wake delay 3 us
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_idle_request <= 1'b0;
      cpu_idle <= 1'b0;
      pgm_fail <= 1'b0;
      flash_power_down <= 1'b0;
      wake_cnt <= 12'h000;
    end else if (clk_en) begin
      if (wr_en && paddr == `BSSL_OFF_CTRL) begin
        flash_idle_request <= pwdata[`BSSL_CTRL_FLASH_IDLE_REQUEST];
        cpu_idle <= pwdata[`BSSL_CTRL_IDLE];
        pgm_fail <= pwdata[`BSSL_CTRL_PGMFAIL];
      end
      if (cpu_idle && flash_idle_request) begin
        flash_power_down <= 1'b1;
        wake_cnt <= 12'(`BSSL_FM_WAKE_CYC);
      end else if (wake_cnt != 12'h000) begin
        wake_cnt <= wake_cnt - 12'h001;
      end else begin
        flash_power_down <= 1'b0;
      end
    end
  end

  // record parser; reply chosen only after the whole line arrived
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= BSSL_BAUD;
      rec_count <= 8'h00;
      rec_addr <= 16'h0000;
      rec_type <= 8'h00;
      sum <= 8'h00;
      nib_idx <= 6'h00;
      hi_nib <= 4'h0;
      reply <= 8'h00;
      last_reply <= 8'h00;
    end else if (clk_en) begin
      case (state)
        BSSL_BAUD: begin
          if (baud_locked) state <= BSSL_WAIT;
        end
        BSSL_WAIT: begin
          if (rx_valid && rx_data == `BSSL_CH_COLON) begin
            state <= BSSL_HDR;
            sum <= 8'h00;
            nib_idx <= 6'h00;
          end
        end
        BSSL_HDR, BSSL_BODY: begin
          if (rx_valid && !nib_ok) begin
            state <= BSSL_WAIT;
          end else if (rx_valid && !nib_idx[0]) begin
            hi_nib <= nib;
            nib_idx <= nib_idx + 6'h01;
          end else if (rx_valid) begin
            sum <= sum + byte_val;
            nib_idx <= nib_idx + 6'h01;
            if (state == BSSL_HDR) begin
              case (nib_idx[2:1])
                2'd0: rec_count <= byte_val;
                2'd1: rec_addr[15:8] <= byte_val;
                2'd2: rec_addr[7:0] <= byte_val;
                default: begin
                  rec_type <= byte_val;
                  nib_idx <= 6'h00;
                  state <= (rec_count == 8'h00) ? BSSL_TAIL : BSSL_BODY;
                end
              endcase
              if (nib_idx[2:1] == 2'd0 && byte_val > {3'b000, `BSSL_MAX_DATA}) begin
                state <= BSSL_WAIT;
              end
            end else if (nib_idx[5:1] == rec_count[4:0] - 5'd1) begin
              state <= BSSL_TAIL;
            end
          end
          if (rx_valid && state == BSSL_TAIL) state <= BSSL_WAIT;
        end
        BSSL_TAIL: begin
          // checksum byte then CR LF; the LF closes the record
          if (rx_valid && nib_ok) begin
            if (nib_idx[0]) sum <= sum + byte_val;
            else hi_nib <= nib;
            nib_idx <= {5'h00, ~nib_idx[0]};
          end else if (rx_valid && rx_data == `BSSL_CH_LF) begin
            state <= BSSL_EXEC;
          end
        end
        BSSL_EXEC: begin
          if (sum != 8'h00) reply <= `BSSL_CH_X;
          else if (rec_type == `BSSL_REC_DATA && pgm_fail) reply <= `BSSL_CH_R;
          else reply <= `BSSL_CH_DOT;
          state <= BSSL_REPLY;
        end
        BSSL_REPLY: begin
          if (!tx_busy && !rx_valid) begin
            last_reply <= reply;
            state <= BSSL_WAIT;
          end
        end
        default: state <= BSSL_BAUD;
      endcase
    end
  end

  // data bytes kept for the programming step
  always_ff @(posedge pclk) begin
    if (clk_en && state == BSSL_BODY && rx_valid && nib_ok && nib_idx[0]) begin
      buffer[nib_idx[4:1]] <= byte_val;
    end
  end

  // echo wins over reply; reply waits until echo drained
  always_comb begin
    tx_start = 1'b0;
    tx_data = rx_data;
    if (rx_valid && !tx_busy) begin
      tx_start = 1'b1;
    end else if (state == BSSL_REPLY && !tx_busy) begin
      tx_start = 1'b1;
      tx_data = reply;
    end
  end

  // apb: zero wait, unmapped answers slverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `BSSL_OFF_CTRL: prdata <= {24'h000000, boot_rom_enable, flash_idle_request,
            3'b000, pgm_fail, 1'b0, cpu_idle};
          `BSSL_OFF_BOOT: prdata <= {vec_psw, vec_pc};
          `BSSL_OFF_LSTAT: prdata <= {16'h0000, last_reply, 4'h0, baud_locked, state};
          `BSSL_OFF_REC: prdata <= {rec_type, rec_count, rec_addr};
          `BSSL_OFF_DATA: prdata <= {24'h000000, buffer[paddr[5:2]]};
          `BSSL_OFF_NVM: prdata <= {24'h000000, status_byte};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= rd_en || pwrite;
          end
        endcase
      end
    end
  end

  // flash is still powered down on the cycle after idle ends
  flash_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && cpu_idle && flash_idle_request ##1 clk_en && !cpu_idle |=> flash_power_down)
    else $error("flash woke too early");
  // nonzero status picks the vector; sampled presetn skips the release edge itself
  boot_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && clk_en && !started && status_byte != `BSSL_ERASED_STATUS
    |=> boot_rom_enable && boot_program_counter == $past(vec_pc))
    else $error("boot vector not taken");
  zero_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && clk_en && !started && status_byte == `BSSL_ERASED_STATUS &&
    program_store_strobe_n |=> boot_program_counter == `BSSL_RESET_PC && !boot_rom_enable)
    else $error("zero status not at 0000");
  bad_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == BSSL_EXEC && sum != 8'h00 |=> reply == `BSSL_CH_X)
    else $error("bad checksum not answered X");
  echo_a: assert property (@(posedge pclk) disable iff (!presetn)
    rx_valid && !tx_busy && clk_en |=> tx_busy)
    else $error("received character not echoed");
  good_dot_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && state == BSSL_EXEC && sum == 8'h00 && !pgm_fail |=> reply == `BSSL_CH_DOT)
    else $error("good record not answered period");
endmodule // bssl_loader

// [verif/bssl_host.sv]
`timescale 1ns/1ps
// host programmer: drives rxd, collects every character seen on txd whose stop bit is high
module bssl_host #(
  parameter int BIT_CYC = 32
) (
  // clock
  input wire logic pclk,
  // serial pins
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rx_q[$];
  logic [7:0] c;
  initial rxd = 1'b1; // mark level while no frame is sent
  // one 8N1 frame, lsb first, then a two-bit gap so echoes keep pace
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    repeat (2 * BIT_CYC) @(posedge pclk);
  endtask
  // sample mid-bit; a frame with a low stop bit is dropped, so it shows as missing
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      c[i] = txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
    if (txd === 1'b1) rx_q.push_back(c);
  end
endmodule // bssl_host

// [verif/boot_select_serial_loader_test.sv]
`timescale 1ns/1ps
`include "bssl_defines.svh"
module boot_select_serial_loader_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, txd, rxd;
  logic program_store_strobe_n = 1'b1;
  logic addr_latch = 1'b0;
  logic external_access_n = 1'b1;
  logic [15:0] boot_program_counter, boot_status_word;
  logic boot_rom_enable, watchdog_disable, flash_power_down, cpu_hold;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #2 pclk = ~pclk;
  bssl_loader dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .program_store_strobe_n(program_store_strobe_n),
    .addr_latch(addr_latch), .external_access_n(external_access_n), .rxd(rxd), .txd(txd),
    .boot_program_counter(boot_program_counter), .boot_status_word(boot_status_word),
    .boot_rom_enable(boot_rom_enable), .watchdog_disable(watchdog_disable),
    .flash_power_down(flash_power_down), .cpu_hold(cpu_hold));
  bssl_host #(.BIT_CYC(32)) host_u (.pclk(pclk), .rxd(rxd), .txd(txd));
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cut a hang short well past the longest expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) check("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, exp, r);
  endtask
  // straps are set while reset is low; the strobe is let go only after release
  task automatic do_reset(input logic strap);
    @(posedge pclk);
    presetn <= 1'b0;
    program_store_strobe_n <= ~strap;
    addr_latch <= strap;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    program_store_strobe_n <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic boot_chk(input logic [15:0] pc, input logic rom, input logic wdd);
    check("boot pc", {16'h0, pc}, {16'h0, boot_program_counter});
    check("boot rom", {31'h0, rom}, {31'h0, boot_rom_enable});
    check("watchdog off", {31'h0, wdd}, {31'h0, watchdog_disable});
    check("cpu hold", 32'h0, {31'h0, cpu_hold});
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction
  // hex record with at most one data byte; bad spoils the checksum
  task automatic send_rec(input logic [7:0] cnt, input logic [15:0] adr, input logic [7:0] typ,
                          input logic bad, input logic [7:0] reply);
    logic [7:0] b[$];
    logic [7:0] s[$];
    logic [7:0] sum;
    int n;
    b = '{cnt, adr[15:8], adr[7:0], typ};
    if (cnt != 8'h00) b.push_back(8'hA5);
    sum = 8'h00;
    foreach (b[i]) sum = sum - b[i];
    b.push_back(sum ^ {7'h0, bad}); // record sums to zero modulo 256 unless bad is set
    s = '{`BSSL_CH_COLON};
    foreach (b[i]) begin
      s.push_back(hexc(b[i][7:4]));
      s.push_back(hexc(b[i][3:0]));
    end
    s.push_back(`BSSL_CH_CR);
    s.push_back(`BSSL_CH_LF);
    host_u.rx_q.delete();
    foreach (s[i]) host_u.send_char(s[i]);
    n = 0;
    while (host_u.rx_q.size() < s.size() + 1 && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    foreach (s[i]) check("echo", {24'h0, s[i]}, {24'h0, host_u.rx_q[i]});
    check("reply", {24'h0, reply}, {24'h0, host_u.rx_q[s.size()]});
  endtask
  task automatic sc_power_on();
    boot_chk(`BSSL_DEF_PC, 1'b1, 1'b1);
    check("boot psw", {16'h0, `BSSL_DEF_PSW}, {16'h0, boot_status_word});
    rd_chk("status", `BSSL_OFF_NVM, 32'h0000_00FF);
  endtask
  task automatic sc_serial();
    logic [31:0] r;
    logic e;
    host_u.send_char(`BSSL_CH_F); // lowercase f first sets the rate
    repeat (600) @(posedge pclk);
    apb(1'b0, `BSSL_OFF_LSTAT, 32'h0, r, e);
    check("baud locked", 32'h8, r & 32'h8);
    send_rec(8'h01, 16'h1234, `BSSL_REC_DATA, 1'b0, `BSSL_CH_DOT);
    rd_chk("record", `BSSL_OFF_REC, 32'h0001_1234);
    send_rec(8'h01, 16'h2000, `BSSL_REC_DATA, 1'b1, `BSSL_CH_X);
    rd_chk("record kept", `BSSL_OFF_REC, 32'h0001_2000); // header stored on arrival
    wr(`BSSL_OFF_CTRL, 32'h0000_0082);
    send_rec(8'h01, 16'h3000, `BSSL_REC_DATA, 1'b0, `BSSL_CH_R);
    wr(`BSSL_OFF_CTRL, 32'h0000_0080);
    send_rec(8'h00, 16'h0000, `BSSL_REC_EOF, 1'b0, `BSSL_CH_DOT);
  endtask
  task automatic sc_boot_select();
    wr(`BSSL_OFF_NVM, 32'h0); // status erased to zero after programming
    do_reset(1'b0);
    boot_chk(`BSSL_RESET_PC, 1'b0, 1'b0);
    do_reset(1'b1);
    boot_chk(`BSSL_DEF_PC, 1'b1, 1'b1);
    wr(`BSSL_OFF_BOOT, {`BSSL_DEF_PSW, 16'hC000}); // custom loader vector
    do_reset(1'b1);
    boot_chk(16'hC000, 1'b1, 1'b0); // user loader must stop the watchdog itself
  endtask
  task automatic sc_special_cells();
    logic [31:0] r;
    logic e;
    wr(`BSSL_OFF_CTRL, 32'h0000_0088);
    rd_chk("erased status", `BSSL_OFF_NVM, 32'h0);
    rd_chk("erased vector", `BSSL_OFF_BOOT, 32'h0);
    wr(`BSSL_OFF_CTRL, 32'h0000_0084);
    rd_chk("error status", `BSSL_OFF_NVM, {24'h0, `BSSL_ERROR_STATUS});
    wr(`BSSL_OFF_BOOT, {`BSSL_DEF_PSW, `BSSL_DEF_PC}); // vector rewritten after status
    do_reset(1'b0);
    boot_chk(`BSSL_DEF_PC, 1'b1, 1'b1);
    check("boot psw", {16'h0, `BSSL_DEF_PSW}, {16'h0, boot_status_word});
    apb(1'b0, 12'hFFC, 32'h0, r, e);
    check("unmapped error", 32'h1, {31'h0, e});
  endtask
  task automatic sc_flash_idle();
    wr(`BSSL_OFF_CTRL, 32'h0000_00C0); // request set just before idle
    wr(`BSSL_OFF_CTRL, 32'h0000_00C1);
    repeat (4) @(posedge pclk);
    check("flash down", 32'h1, {31'h0, flash_power_down});
    wr(`BSSL_OFF_CTRL, 32'h0000_0080); // idle ends at this write
    repeat (`BSSL_FM_WAKE_CYC) @(posedge pclk);
    check("flash waking", 32'h1, {31'h0, flash_power_down});
    repeat (2) @(posedge pclk);
    check("flash up", 32'h0, {31'h0, flash_power_down});
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    sc_power_on();
    sc_serial();
    sc_special_cells();
    sc_flash_idle();
    sc_boot_select();
    summarize();
  end
endmodule // boot_select_serial_loader_test
